// ===== src/arb_request_clear.sv
// Pending fair and priority arbitration requests and their clearing
`timescale 1ns/1ps
`default_nettype none

module arb_request_clear (
    input wire logic clk,
    input wire logic rst,
    input wire logic null_packet_action_flag,
    input wire logic fair_req_set,
    input wire logic pri_req_set,
    input wire logic pkt_end,
    input wire logic [15:0] pkt_bits,
    output logic fair_pending,
    output logic pri_pending
);

    logic clear_req;

    // Decide whether the packet just ended clears the pending requests
    always_comb begin
        if (!pkt_end) begin
            clear_req = 1'b0;
        end else if (null_packet_action_flag) begin
            clear_req = pkt_bits > phy_pages_pkg::ACK_PACKET_BITS;
        end else begin
            clear_req = pkt_bits != phy_pages_pkg::ACK_PACKET_BITS;
        end
    end

    // A new request in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            fair_pending <= 1'b0;
        end else if (fair_req_set) begin
            fair_pending <= 1'b1;
        end else if (clear_req) begin
            fair_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pri_pending <= 1'b0;
        end else if (pri_req_set) begin
            pri_pending <= 1'b1;
        end else if (clear_req) begin
            pri_pending <= 1'b0;
        end
    end

endmodule // arb_request_clear

`default_nettype wire

// ===== src/phy_ident_and_vendor_pages.sv
// Paged identification and vendor control registers with Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// - Page selector value 1 maps the identification page onto paged words.
// - Page selector value 7 maps the vendor control page onto paged words.
// - Identification page returns read-only compliance level 01h.
// - Read-only 24-bit maker identifier, high byte at paged address 1010b.
// - Read-only 24-bit product identifier, high byte at paged address 1101b.
// - Flag set: requests cleared only by packets longer than 8 bits.
// - Flag clear: requests cleared by any non-acknowledge packet.
// - Null-packet flag is read/write, zero after reset, cleared by bus reset.
// - Two-bit link speed: 00 S100, 01 S200, 10 S400, 11 illegal.
// - Link speed field is copied into the self-ID speed bits.
// - Peers are always told S400 capability during self-ID.
// - Link speed resets to S400 and survives bus reset.
// - Power-class pins loaded after reset as self-ID power class.
// - Later writes to the power-class register replace the pin default.
// - Power-class codes decode into power need and supply categories.
module phy_ident_and_vendor_pages #(
    parameter logic [23:0] MAKER_OUI = 24'h123456,
    parameter logic [23:0] PRODUCT_CODE = 24'hABCDEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic bus_reset,
    input wire logic [2:0] power_class_pins,
    input wire logic fair_req_set,
    input wire logic pri_req_set,
    input wire logic pkt_end,
    input wire logic [15:0] pkt_bits,
    output logic fair_pending,
    output logic pri_pending,
    output logic null_packet_action_flag,
    output logic [1:0] selfid_speed,
    output logic [1:0] peer_speed,
    output logic [2:0] selfid_power,
    output logic power_class_self,
    output logic power_class_bus,
    output logic power_class_needs,
    output logic power_class_reserved,
    output logic link_speed_illegal
);
    // MAKER_OUI and PRODUCT_CODE defaults are arbitrary values

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake state

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;
    logic [3:0] word_index;
    logic word_in_map;
    logic bus_req;
    logic write_fire;
    logic low_byte_write;

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [2:0] page_sel_reg;
    logic [2:0] power_class_reg;
    logic power_loaded_reg;
    logic null_act_reg;
    logic [1:0] link_speed_reg;
    logic [7:0] read_byte;
    logic [31:0] readdata_next;

    assign word_index = avs_address[5:2];
    assign word_in_map = (avs_address[7:6] == 2'h0);
    assign bus_req = avs_read | avs_write;
    assign write_fire = avs_write && (bus_state_reg == BUS_DONE);
    assign low_byte_write = write_fire && avs_byteenable[0] && word_in_map;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then answer

    always_comb begin
        case (bus_state_reg)
            BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_next = BUS_DONE;
                end else begin
                    bus_state_next = BUS_IDLE;
                end
            end
            BUS_DONE: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state_reg <= BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_state_reg == BUS_IDLE && bus_req);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    always_comb begin
        read_byte = 8'h00;
        if (!word_in_map) begin
            read_byte = 8'h00;
        end else if (word_index == phy_pages_pkg::IDX_PAGE_SELECT) begin
            read_byte = {5'h00, page_sel_reg};
        end else if (word_index == phy_pages_pkg::IDX_POWER_CLASS) begin
            read_byte = {5'h00, power_class_reg};
        end else if (word_index[3] && page_sel_reg ==
                     phy_pages_pkg::PAGE_IDENT) begin
            case (word_index)
                phy_pages_pkg::IDX_COMPLIANCE: begin
                    read_byte = phy_pages_pkg::COMPLIANCE_VALUE;
                end
                phy_pages_pkg::IDX_ORG_HI: begin
                    read_byte = MAKER_OUI[23:16];
                end
                phy_pages_pkg::IDX_ORG_MID: begin
                    read_byte = MAKER_OUI[15:8];
                end
                phy_pages_pkg::IDX_ORG_LO: begin
                    read_byte = MAKER_OUI[7:0];
                end
                phy_pages_pkg::IDX_PROD_HI: begin
                    read_byte = PRODUCT_CODE[23:16];
                end
                phy_pages_pkg::IDX_PROD_MID: begin
                    read_byte = PRODUCT_CODE[15:8];
                end
                phy_pages_pkg::IDX_PROD_LO: begin
                    read_byte = PRODUCT_CODE[7:0];
                end
                default: begin
                    read_byte = 8'h00;
                end
            endcase
        end else if (word_index == phy_pages_pkg::IDX_VENDOR_CTRL &&
                     page_sel_reg == phy_pages_pkg::PAGE_VENDOR) begin
            read_byte = 8'h00;
            read_byte[phy_pages_pkg::NULL_ACT_BIT] = null_act_reg;
            read_byte[phy_pages_pkg::LINK_SPEED_LSB +: 2] = link_speed_reg;
        end else begin
            read_byte = 8'h00;
        end
    end

    assign readdata_next = {24'h000000, read_byte};

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_state_reg == BUS_IDLE && avs_read) begin
            avs_readdata <= readdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers

    always_ff @(posedge clk) begin
        if (rst) begin
            page_sel_reg <= phy_pages_pkg::PAGE_SEL_RESET;
        end else if (low_byte_write &&
                     word_index == phy_pages_pkg::IDX_PAGE_SELECT) begin
            page_sel_reg <=
                avs_writedata[phy_pages_pkg::PAGE_SEL_LSB +: 3];
        end
    end

    // Vendor page write; all other paged words ignore writes
    logic vendor_write;
    assign vendor_write = low_byte_write &&
                          word_index == phy_pages_pkg::IDX_VENDOR_CTRL &&
                          page_sel_reg == phy_pages_pkg::PAGE_VENDOR;

    always_ff @(posedge clk) begin
        if (rst) begin
            null_act_reg <= phy_pages_pkg::NULL_ACT_RESET;
        end else if (vendor_write) begin
            null_act_reg <=
                avs_writedata[phy_pages_pkg::NULL_ACT_BIT];
        end else if (bus_reset) begin
            null_act_reg <= phy_pages_pkg::NULL_ACT_RESET;
        end
    end

    // Bus reset leaves the link speed alone
    always_ff @(posedge clk) begin
        if (rst) begin
            link_speed_reg <= phy_pages_pkg::LINK_SPEED_RESET;
        end else if (vendor_write) begin
            link_speed_reg <=
                avs_writedata[phy_pages_pkg::LINK_SPEED_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power class: pin default after reset, register writes override

    always_ff @(posedge clk) begin
        if (rst) begin
            power_loaded_reg <= 1'b0;
        end else begin
            power_loaded_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_class_reg <= phy_pages_pkg::PWR_NONE;
        end else if (low_byte_write &&
                     word_index == phy_pages_pkg::IDX_POWER_CLASS) begin
            power_class_reg <=
                avs_writedata[phy_pages_pkg::PWR_CLASS_LSB +: 3];
        end else if (!power_loaded_reg) begin
            power_class_reg <= power_class_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-ID fields and decoded status

    always_ff @(posedge clk) begin
        if (rst) begin
            selfid_speed <= phy_pages_pkg::LINK_SPEED_RESET;
        end else begin
            selfid_speed <= link_speed_reg;
        end
    end

    // Peers always hear S400, whatever the link can do
    always_ff @(posedge clk) begin
        if (rst) begin
            peer_speed <= phy_pages_pkg::SPEED_S400;
        end else begin
            peer_speed <= phy_pages_pkg::SPEED_S400;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            selfid_power <= phy_pages_pkg::PWR_NONE;
        end else begin
            selfid_power <= power_class_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            null_packet_action_flag <= phy_pages_pkg::NULL_ACT_RESET;
        end else begin
            null_packet_action_flag <= null_act_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            link_speed_illegal <= 1'b0;
        end else begin
            link_speed_illegal <=
                link_speed_reg == phy_pages_pkg::SPEED_ILLEGAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_class_self <= 1'b0;
            power_class_bus <= 1'b0;
            power_class_needs <= 1'b0;
            power_class_reserved <= 1'b0;
        end else begin
            power_class_self <= 1'b0;
            power_class_bus <= 1'b0;
            power_class_needs <= 1'b0;
            power_class_reserved <= 1'b0;
            case (power_class_reg)
                phy_pages_pkg::PWR_NONE: begin
                    power_class_self <= 1'b0;
                end
                phy_pages_pkg::PWR_SELF_15W,
                phy_pages_pkg::PWR_SELF_30W,
                phy_pages_pkg::PWR_SELF_45W: begin
                    power_class_self <= 1'b1;
                end
                phy_pages_pkg::PWR_BUS_3W: begin
                    power_class_bus <= 1'b1;
                end
                phy_pages_pkg::PWR_RESERVED: begin
                    power_class_reserved <= 1'b1;
                end
                phy_pages_pkg::PWR_NEED_3W,
                phy_pages_pkg::PWR_NEED_7W: begin
                    power_class_bus <= 1'b1;
                    power_class_needs <= 1'b1;
                end
                default: begin
                    power_class_reserved <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration request clearing

    arb_request_clear u_arb (
        .clk(clk),
        .rst(rst),
        .null_packet_action_flag(null_act_reg),
        .fair_req_set(fair_req_set),
        .pri_req_set(pri_req_set),
        .pkt_end(pkt_end),
        .pkt_bits(pkt_bits),
        .fair_pending(fair_pending),
        .pri_pending(pri_pending)
    );

endmodule // phy_ident_and_vendor_pages

`default_nettype wire

// ===== src/phy_pages_pkg.sv
// Constants shared by the paged extension register block
package phy_pages_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_POWER_CLASS = 4'h4;
    localparam logic [3:0] IDX_PAGE_SELECT = 4'h7;
    localparam logic [3:0] IDX_COMPLIANCE = 4'h8;
    localparam logic [3:0] IDX_VENDOR_CTRL = 4'h8;
    localparam logic [3:0] IDX_ORG_HI = 4'hA;
    localparam logic [3:0] IDX_ORG_MID = 4'hB;
    localparam logic [3:0] IDX_ORG_LO = 4'hC;
    localparam logic [3:0] IDX_PROD_HI = 4'hD;
    localparam logic [3:0] IDX_PROD_MID = 4'hE;
    localparam logic [3:0] IDX_PROD_LO = 4'hF;

    // Page selector values
    localparam logic [2:0] PAGE_IDENT = 3'h1;
    localparam logic [2:0] PAGE_VENDOR = 3'h7;

    // Field positions
    localparam int PAGE_SEL_LSB = 0;
    localparam int PWR_CLASS_LSB = 0;
    localparam int NULL_ACT_BIT = 7;
    localparam int LINK_SPEED_LSB = 0;

    // Reset values and fixed contents
    localparam logic [7:0] COMPLIANCE_VALUE = 8'h01;
    localparam logic [2:0] PAGE_SEL_RESET = 3'h0;
    localparam logic NULL_ACT_RESET = 1'b0;
    localparam logic [1:0] LINK_SPEED_RESET = 2'h2;

    // Link speed codes
    localparam logic [1:0] SPEED_S100 = 2'h0;
    localparam logic [1:0] SPEED_S200 = 2'h1;
    localparam logic [1:0] SPEED_S400 = 2'h2;
    localparam logic [1:0] SPEED_ILLEGAL = 2'h3;

    // Power class codes
    localparam logic [2:0] PWR_NONE = 3'h0;
    localparam logic [2:0] PWR_SELF_15W = 3'h1;
    localparam logic [2:0] PWR_SELF_30W = 3'h2;
    localparam logic [2:0] PWR_SELF_45W = 3'h3;
    localparam logic [2:0] PWR_BUS_3W = 3'h4;
    localparam logic [2:0] PWR_RESERVED = 3'h5;
    localparam logic [2:0] PWR_NEED_3W = 3'h6;
    localparam logic [2:0] PWR_NEED_7W = 3'h7;

    // Length of an acknowledge packet in bits
    localparam logic [15:0] ACK_PACKET_BITS = 16'h0008;

endpackage

// ===== tb/link_pkt_model.sv
// Far-side packet and request source
`timescale 1ns/1ps
`default_nettype none

module link_pkt_model (
    input wire logic clk,
    output var logic fair_req_set,
    output var logic pri_req_set,
    output var logic pkt_end,
    output var logic [15:0] pkt_bits
);
    initial begin
        fair_req_set = 1'b0;
        pri_req_set = 1'b0;
        pkt_end = 1'b0;
        pkt_bits = 16'h0000;
    end

    task automatic request();
        @(posedge clk);
        fair_req_set <= 1'b1;
        pri_req_set <= 1'b1;
        @(posedge clk);
        fair_req_set <= 1'b0;
        pri_req_set <= 1'b0;
    endtask

    // Length is only valid with the end pulse; scramble it afterwards
    task automatic packet(input logic [15:0] n);
        @(posedge clk);
        pkt_end <= 1'b1;
        pkt_bits <= n;
        @(posedge clk);
        pkt_end <= 1'b0;
        pkt_bits <= ~n;
    endtask
endmodule // link_pkt_model

`default_nettype wire

// ===== tb/phy_ident_and_vendor_pages_test.sv
// Self-checking bench for the paged register block
`timescale 1ns/1ps
`default_nettype none

module phy_ident_and_vendor_pages_test;
    localparam logic [23:0] OUI = 24'h3C5A96; // Arbitrary value
    localparam logic [23:0] PROD = 24'h81E247; // Arbitrary value
    logic clk, rst, avs_read, avs_write, bus_reset, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [3:0] avs_byteenable;
    logic [2:0] power_class_pins, selfid_power, c;
    logic fair_req_set, pri_req_set, pkt_end, fair_pending, pri_pending;
    logic flag_out, ps_self, ps_bus, ps_need, ps_res, sp_ill, f;
    logic [15:0] pkt_bits;
    logic [1:0] selfid_speed, peer_speed;
    logic [7:0] id_tab [8];
    logic [15:0] len_tab [4];
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    phy_ident_and_vendor_pages #(.MAKER_OUI(OUI), .PRODUCT_CODE(PROD)) dut (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .bus_reset(bus_reset), .power_class_pins(power_class_pins),
        .fair_req_set(fair_req_set), .pri_req_set(pri_req_set),
        .pkt_end(pkt_end), .pkt_bits(pkt_bits),
        .fair_pending(fair_pending), .pri_pending(pri_pending),
        .null_packet_action_flag(flag_out), .selfid_speed(selfid_speed),
        .peer_speed(peer_speed), .selfid_power(selfid_power),
        .power_class_self(ps_self), .power_class_bus(ps_bus),
        .power_class_needs(ps_need), .power_class_reserved(ps_res),
        .link_speed_illegal(sp_ill));

    link_pkt_model lnk (.clk(clk), .fair_req_set(fair_req_set),
        .pri_req_set(pri_req_set), .pkt_end(pkt_end), .pkt_bits(pkt_bits));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Hold request until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
        bus_xfer(1'b1, a, wd, 4'hF);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        bus_xfer(1'b0, a, 32'h00000000, 4'hF);
        chk(nm, e, d);
    endtask

    task automatic summarize();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        id_tab = '{phy_pages_pkg::COMPLIANCE_VALUE, 8'h00, OUI[23:16],
                   OUI[15:8], OUI[7:0], PROD[23:16], PROD[15:8], PROD[7:0]};
        len_tab = '{16'h0000, 16'h0005, 16'h0008, 16'h0009};
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        bus_reset = 1'b0;
        power_class_pins = 3'h5;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk("selfid_power", 32'h5, {29'h0, selfid_power});
        rd_chk("pwr_class", 8'h10, 32'h5);
        rd_chk("page_sel", 8'h1C, 32'h0);
        bus_wr(8'h1C, 32'h1);
        bus_wr(8'h28, 32'hFF);
        for (int i = 0; i < 8; i++) begin
            rd_chk("ident_page", 8'h20 + 8'(4 * i),
                   {24'h0, id_tab[i]});
        end
        bus_wr(8'h1C, 32'h7);
        rd_chk("vendor_ctrl", 8'h20, 32'h2);
        rd_chk("test_word", 8'h2C, 32'h0);
        for (int s = 0; s < 4; s++) begin
            bus_wr(8'h20, 32'(s));
            rd_chk("link_speed", 8'h20, 32'(s));
            @(negedge clk);
            chk("selfid_speed", 32'(s), {30'h0, selfid_speed});
            chk("peer_speed", 32'h2, {30'h0, peer_speed});
            chk("speed_ill", 32'(s == 3), {31'h0, sp_ill});
        end
        bus_wr(8'h20, 32'h81);
        rd_chk("flag_set", 8'h20, 32'h81);
        @(negedge clk);
        chk("flag_out", 32'h1, {31'h0, flag_out});
        @(posedge clk);
        bus_reset <= 1'b1;
        @(posedge clk);
        bus_reset <= 1'b0;
        rd_chk("after_bus_rst", 8'h20, 32'h1);
        @(negedge clk);
        chk("flag_out", 32'h0, {31'h0, flag_out});
        bus_xfer(1'b1, 8'h20, 32'h82, 4'hE);
        rd_chk("be_dropped", 8'h20, 32'h1);
        for (int k = 0; k < 2; k++) begin
            f = k[0];
            bus_wr(8'h20, {24'h0, f, 7'h02});
            foreach (len_tab[j]) begin
                lnk.request();
                lnk.packet(len_tab[j]);
                @(negedge clk);
                c = f ? 3'(len_tab[j] > 8) : 3'(len_tab[j] != 8);
                chk("fair_pend", {31'h0, !c[0]},
                    {31'h0, fair_pending});
                chk("pri_pend", {31'h0, !c[0]},
                    {31'h0, pri_pending});
            end
        end
        for (int p = 0; p < 8; p++) begin
            c = 3'(p);
            bus_wr(8'h10, 32'(p));
            repeat (2) @(negedge clk);
            chk("pwr_self", 32'(p), {29'h0, selfid_power});
            chk("pwr_decode", {28'h0, c inside {1, 2, 3},
                c inside {4, 6, 7}, c[2:1] == 2'h3, c == 5},
                {28'h0, ps_self, ps_bus, ps_need, ps_res});
        end
        bus_wr(8'hC0, 32'h55);
        rd_chk("unmapped", 8'hC0, 32'h0);
        bus_wr(8'h1C, 32'h0);
        rd_chk("other_page", 8'h20, 32'h0);
        summarize();
    end
endmodule // phy_ident_and_vendor_pages_test

`default_nettype wire

// ===== tb/phy_pages_sva.sv
// Port checker for the paged register block
`timescale 1ns/1ps
`default_nettype none

module phy_pages_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic fair_req_set,
    input wire logic pri_req_set,
    input wire logic pkt_end,
    input wire logic [15:0] pkt_bits,
    input wire logic fair_pending,
    input wire logic pri_pending,
    input wire logic null_packet_action_flag,
    input wire logic [1:0] selfid_speed,
    input wire logic [1:0] peer_speed,
    input wire logic [2:0] selfid_power,
    input wire logic power_class_self,
    input wire logic power_class_bus,
    input wire logic power_class_needs,
    input wire logic power_class_reserved,
    input wire logic link_speed_illegal
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus request not answered in one cycle");
    a_wait_pulse: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("Answer cycle longer than one cycle");
    a_upper_zero: assert property (
        avs_readdata[31:8] == 24'h000000)
        else $error("Read data upper bits not zero");
    a_peer_s400: assert property (peer_speed == 2'h2)
        else $error("Peer speed not S400");
    a_fair_set: assert property (fair_req_set |=> fair_pending)
        else $error("Fair request not pending");
    a_pri_set: assert property (pri_req_set |=> pri_pending)
        else $error("Priority request not pending");
    a_null_hold: assert property (
        (pkt_end && pkt_bits <= 16'h0008 && fair_pending && pri_pending
         && !fair_req_set && !pri_req_set) ##1 null_packet_action_flag
        |-> fair_pending && pri_pending)
        else $error("Short packet cleared requests with flag set");
    a_null_clear: assert property (
        (pkt_end && pkt_bits != 16'h0008 && !fair_req_set && !pri_req_set)
        ##1 !null_packet_action_flag |-> !fair_pending && !pri_pending)
        else $error("Non-ack packet left requests with flag clear");
    a_ack_keep: assert property (
        pkt_end && pkt_bits == 16'h0008 && fair_pending && !fair_req_set
        |=> fair_pending)
        else $error("Acknowledge packet cleared fair request");
    a_speed_flag: assert property (
        link_speed_illegal == (selfid_speed == 2'h3))
        else $error("Illegal speed flag mismatch");
    a_pwr_decode: assert property (
        power_class_self == (selfid_power inside {3'h1, 3'h2, 3'h3})
        && power_class_bus == (selfid_power inside {3'h4, 3'h6, 3'h7})
        && power_class_needs == (selfid_power[2:1] == 2'h3)
        && power_class_reserved == (selfid_power == 3'h5))
        else $error("Power class decode mismatch");
endmodule // phy_pages_sva

bind phy_ident_and_vendor_pages phy_pages_sva chk_i (
    .clk, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .fair_req_set, .pri_req_set, .pkt_end, .pkt_bits, .fair_pending,
    .pri_pending, .null_packet_action_flag, .selfid_speed, .peer_speed,
    .selfid_power, .power_class_self, .power_class_bus, .power_class_needs,
    .power_class_reserved, .link_speed_illegal
);

`default_nettype wire
